// ### common/qdn_pkg.sv
/*
  Shared constants, types and helpers for the quad converter control core.
  Assumes one core clock at 250 MHz; serial pins arrive from outside that domain.
*/
package qdn_pkg;

  // ==========================================================
  // frame layout and register set
  localparam int DATA_BITS = 8;
  localparam int NUM_CONV = 4;
  localparam int NUM_REGS = 5;
  localparam logic [3:0] FRAME_CNT = 4'hE;
  localparam logic [3:0] HDR_LAST = 4'h5;
  localparam logic [3:0] CNT_MAX = 4'hF;
  localparam logic [2:0] SEL_MS = 3'h4;
  localparam int MUTE_LSB = 4;
  localparam int SHDN_LSB = 0;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [3:0] ALL_SHDN = 4'hF;

  // ==========================================================
  // timing
  localparam int STORE_TIME_MS = 13;
  localparam int CLK_KHZ = 250000;
  localparam int STORE_CYCLES = STORE_TIME_MS * CLK_KHZ;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    CMD_NV_WR = 2'h0,
    CMD_VOL_WR = 2'h1,
    CMD_NV_RD = 2'h2,
    CMD_NONE = 2'h3
  } qdn_cmd_type;

  typedef struct packed {
    logic start;
    qdn_cmd_type cmd;
    logic [2:0] sel;
    logic [7:0] data;
  } qdn_frame_type;

  typedef struct packed {
    logic [3:0][7:0] code;
    logic [3:0] mute;
    logic [3:0] hiz;
  } qdn_conv_type;

  typedef struct packed {
    logic wr;
    logic [2:0] sel;
    logic [7:0] data;
  } qdn_nv_req_type;

  function automatic logic qdn_sel_ok(input logic [2:0] sel);
    return sel <= SEL_MS;
  endfunction : qdn_sel_ok

endpackage : qdn_pkg

// ### hdl/qdn_nv_store.sv
/*
  Nonvolatile register array with a timed store cycle.
  Assumes the caller issues no store while busy is high; such a request is dropped.
*/
`timescale 1ns/1ns
module qdn_nv_store import qdn_pkg::*; #(
  parameter int STORE_CYCLES_P = STORE_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // store request
  input wire qdn_nv_req_type req,
  output logic busy,
  // read port
  input wire logic [2:0] rd_sel,
  output logic [7:0] rd_data
);

  localparam int CW = $clog2(STORE_CYCLES_P + 1);

  // ==========================================================
  // storage
  // power-up value models a blank part; not touched by reset
  logic [7:0] mem [NUM_REGS] = '{default: REG_RESET};
  logic [CW-1:0] cnt;
  logic [2:0] pend_sel;
  logic [7:0] pend_data;

  wire start_store = req.wr && !busy && qdn_sel_ok(req.sel);
  wire store_done = busy && (cnt == CW'(1));

  if (STORE_CYCLES_P < 1) begin : g_bad_cycles
    $error("STORE_CYCLES_P must be at least 1");
  end

  // ==========================================================
  // store timer
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      busy <= 1'b0;
      cnt <= '0;
    end else if (busy) begin
      cnt <= cnt - CW'(1);
      if (store_done) busy <= 1'b0;
    end else if (start_store) begin
      busy <= 1'b1;
      cnt <= CW'(STORE_CYCLES_P);
    end
  end

  always_ff @(posedge core_clk) begin
    if (start_store) begin
      pend_sel <= req.sel;
      pend_data <= req.data;
    end
  end

  // a power loss mid-store leaves the old value in place
  always_ff @(posedge core_clk) begin
    if (store_done) mem[pend_sel] <= pend_data;
  end

  assign rd_data = qdn_sel_ok(rd_sel) ? mem[rd_sel] : REG_RESET;

endmodule : qdn_nv_store

// ### hdl/qdn_core.sv
/*
  Control core of a quad 8-bit converter with nonvolatile register copies.
  Assumes host pins (serial clock, select, data, mute) are asynchronous to
  core_clk and that the serial clock is far slower than core_clk.
*/
`timescale 1ns/1ns
module qdn_core import qdn_pkg::*; #(
  parameter int STORE_CYCLES_P = STORE_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // serial port pins
  input wire logic serial_clk,
  input wire logic chip_select_n,
  input wire logic serial_din,
  output logic serial_dout,
  output logic serial_dout_oe_n,
  // external mute pin
  input wire logic ext_mute,
  // open-drain status pin
  input wire logic store_status_in,
  output logic store_status_out,
  output logic store_status_oe_n,
  // converter controls
  output qdn_conv_type conv_out
);

  // ==========================================================
  // state
  typedef enum logic [1:0] {
    ST_BOOT = 2'b01,
    ST_RUN = 2'b10
  } qdn_state_type;

  qdn_state_type state;
  logic [2:0] boot_idx;
  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  logic [1:0] pin_prev;
  logic [FRAME_CNT-1:0] shreg;
  logic [3:0] bit_cnt;
  logic [6:0] dout_shift;
  logic [3:0][7:0] code;
  logic [7:0] mute_shdn;
  logic nv_busy;
  logic [7:0] nv_rd_data;
  qdn_nv_req_type nv_req;
  qdn_conv_type next_conv;

  // ==========================================================
  // pin synchronisers: 0 clock, 1 select, 2 data, 3 mute
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pin_meta <= 4'h2;
      pin_sync <= 4'h2;
      pin_prev <= 2'h2;
    end else begin
      pin_meta <= {ext_mute, serial_din, chip_select_n, serial_clk};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync[1:0];
    end
  end

  wire sclk_rise = pin_sync[0] && !pin_prev[0];
  wire cs_low = !pin_sync[1];
  wire cs_rise = pin_sync[1] && !pin_prev[1];
  wire din_s = pin_sync[2];
  wire mute_s = pin_sync[3];
  wire running = (state == ST_RUN);

  // ==========================================================
  // frame capture and decode
  wire shift_en = cs_low && sclk_rise && (bit_cnt != CNT_MAX);
  wire qdn_frame_type frame = qdn_frame_type'(shreg);
  wire frame_ok = cs_rise && running && (bit_cnt == FRAME_CNT) && frame.start
                  && qdn_sel_ok(frame.sel);
  wire vol_wr = frame_ok && (frame.cmd == CMD_VOL_WR);
  wire vol_wr_ms = vol_wr && (frame.sel == SEL_MS);
  wire vol_wr_code = vol_wr && (frame.sel != SEL_MS);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      shreg <= '0;
      bit_cnt <= '0;
    end else if (!cs_low) begin
      bit_cnt <= '0;
    end else if (shift_en) begin
      shreg <= {shreg[FRAME_CNT-2:0], din_s};
      bit_cnt <= bit_cnt + 4'h1;
    end
  end

  // header completes on the sixth clock edge of the frame
  wire [5:0] hdr = {shreg[4:0], din_s};
  wire hdr_done = shift_en && (bit_cnt == HDR_LAST);
  wire hdr_read = hdr_done && running && hdr[5] && (hdr[4:3] == CMD_NV_RD)
                  && qdn_sel_ok(hdr[2:0]);

  // ==========================================================
  // nonvolatile group
  assign nv_req.wr = frame_ok && (frame.cmd == CMD_NV_WR);
  assign nv_req.sel = frame.sel;
  assign nv_req.data = frame.data;
  wire [2:0] nv_rd_sel = running ? hdr[2:0] : boot_idx;

  qdn_nv_store #(
    .STORE_CYCLES_P(STORE_CYCLES_P)
  ) u_nv_store (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .req(nv_req),
    .busy(nv_busy),
    .rd_sel(nv_rd_sel),
    .rd_data(nv_rd_data)
  );

  // ==========================================================
  // read-back shifter: one bit per rising edge, msb first
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      serial_dout <= 1'b0;
      serial_dout_oe_n <= 1'b1;
      dout_shift <= '0;
    end else if (!cs_low) begin
      serial_dout_oe_n <= 1'b1;
    end else if (hdr_read) begin
      serial_dout <= nv_rd_data[7];
      dout_shift <= nv_rd_data[6:0];
      serial_dout_oe_n <= 1'b0;
    end else if (shift_en && !serial_dout_oe_n) begin
      serial_dout <= dout_shift[6];
      dout_shift <= {dout_shift[5:0], 1'b0};
    end
  end

  // ==========================================================
  // power-up copy, one register per core clock
  wire boot_step = (state == ST_BOOT);
  wire boot_last = (boot_idx == SEL_MS);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state <= ST_BOOT;
      boot_idx <= '0;
    end else begin
      unique case (state)
        ST_BOOT: begin
          boot_idx <= boot_idx + 3'h1;
          if (boot_last) state <= ST_RUN;
        end
        ST_RUN: state <= ST_RUN;
      endcase
    end
  end

  // ==========================================================
  // volatile group
  // full shutdown drops the codes, like the analog part powering down
  wire all_off = (mute_shdn[SHDN_LSB +: NUM_CONV] == ALL_SHDN);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      code <= {NUM_CONV{REG_RESET}};
      mute_shdn <= REG_RESET;
    end else begin
      if (boot_step && !boot_last) code[boot_idx[1:0]] <= nv_rd_data;
      if (boot_step && boot_last) mute_shdn <= nv_rd_data;
      if (vol_wr_code) code[frame.sel[1:0]] <= frame.data;
      if (vol_wr_ms) mute_shdn <= frame.data;
      if (all_off) code <= {NUM_CONV{REG_RESET}};
    end
  end

  // ==========================================================
  // converter controls
  assign next_conv.code = code;
  assign next_conv.mute = mute_shdn[MUTE_LSB +: NUM_CONV]
                          | {NUM_CONV{mute_s}};
  assign next_conv.hiz = mute_shdn[SHDN_LSB +: NUM_CONV];

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      conv_out <= '0;
    end else begin
      conv_out <= next_conv;
    end
  end

  // ==========================================================
  // status pin: pull low while a store is in progress
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      store_status_out <= 1'b0;
      store_status_oe_n <= 1'b1;
    end else begin
      store_status_out <= 1'b0;
      store_status_oe_n <= !nv_busy;
    end
  end

endmodule : qdn_core

// ### sim/qdn_props.sv
/*
  Concurrent checks on the quad converter control core's pins.
  Assumes binding into qdn_core; the pins from outside are watched as seen at the core.
*/
`timescale 1ns/1ns
module qdn_props import qdn_pkg::*; #(
  parameter int STORE_CYCLES_P = STORE_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // watched pins
  input wire logic chip_select_n,
  input wire logic ext_mute,
  input wire logic serial_dout_oe_n,
  input wire logic store_status_out,
  input wire logic store_status_oe_n,
  input wire qdn_conv_type conv_out
);
  // ====================
  // helper counters; cs_hi and since_rst saturate at 99 so a long idle never wraps
  int busy_cnt;
  int cs_hi;
  int since_rst;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      busy_cnt <= 0;
      cs_hi <= 0;
      since_rst <= 0;
    end else begin
      busy_cnt <= store_status_oe_n ? 0 : busy_cnt + 1;
      cs_hi <= !chip_select_n ? 0 : (cs_hi < 99) ? cs_hi + 1 : cs_hi;
      since_rst <= (since_rst < 99) ? since_rst + 1 : since_rst;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // ====================
  // properties
  a_status_low: assert property (store_status_out == 1'b0)
    else $error("status pin driven high");
  a_reset_clear: assert property (disable iff (1'b0) sys_rst |=> conv_out == '0)
    else $error("converter state not cleared by reset");
  a_ext_mute_all: assert property (ext_mute [*4] |-> conv_out.mute == 4'hF)
    else $error("external mute missed a converter");
  a_shdn_clears: assert property ((conv_out.hiz == 4'hF) [*2] |-> conv_out.code == '0)
    else $error("codes kept in full shutdown");
  a_busy_bound: assert property (!store_status_oe_n |-> busy_cnt <= STORE_CYCLES_P + 2)
    else $error("store busy too long");
  a_busy_length: assert property ($rose(store_status_oe_n) |-> busy_cnt >= STORE_CYCLES_P)
    else $error("store busy too short");
  a_busy_after_cs: assert property ($fell(store_status_oe_n) |-> cs_hi inside {[1:10]})
    else $error("store began without a closed frame");
  a_code_after_cs: assert property ($changed(conv_out.code) |->
    cs_hi inside {[1:10]} || since_rst <= 12 || conv_out.hiz == 4'hF)
    else $error("code changed outside a command");
  a_dout_in_frame: assert property (!serial_dout_oe_n |-> cs_hi <= 5)
    else $error("serial output driven outside a frame");
endmodule : qdn_props

bind qdn_core qdn_props #(.STORE_CYCLES_P(STORE_CYCLES_P)) u_props (.core_clk(core_clk),
  .sys_rst(sys_rst), .chip_select_n(chip_select_n), .ext_mute(ext_mute),
  .serial_dout_oe_n(serial_dout_oe_n), .store_status_out(store_status_out),
  .store_status_oe_n(store_status_oe_n), .conv_out(conv_out));

// ### sim/qdn_host.sv
/*
  Host model of the four-wire serial port.
  Assumes core_clk paces the pins; the serial clock is 8 core cycles per bit.
*/
`timescale 1ns/1ns
module qdn_host import qdn_pkg::*; (
  // pacing clock
  input wire logic core_clk,
  // serial port
  output logic serial_clk,
  output logic chip_select_n,
  output logic serial_din,
  input wire logic serial_dout
);
  // ====================
  // frame driver; clock parked low outside frames
  initial begin
    serial_clk = 1'b0;
    chip_select_n = 1'b1;
    serial_din = 1'b0;
  end
  task automatic frame(input qdn_frame_type f, input int nbits, output logic [7:0] rd);
    rd = 8'h00;
    @(negedge core_clk) chip_select_n = 1'b0;
    for (int k = 0; k < nbits; k++) begin
      serial_din = f[13-k];
      repeat (4) @(negedge core_clk);
      serial_clk = 1'b1;
      if (k >= 6) rd = {rd[6:0], serial_dout};
      repeat (4) @(negedge core_clk);
      serial_clk = 1'b0;
    end
    repeat (4) @(negedge core_clk);
    chip_select_n = 1'b1;
    // stale data would hide a sampling slip
    serial_din = ~serial_din;
    repeat (8) @(negedge core_clk);
  endtask : frame
endmodule : qdn_host

// ### sim/tb.sv
/*
  Self-checking bench for the quad converter control core.
  Assumes qdn_host drives the serial pins and a pull-up sits on the status pin.
*/
`timescale 1ns/1ns
module tb import qdn_pkg::*;;
  localparam int STORE_P = 20;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ext_mute = 1'b0;
  logic serial_clk, chip_select_n, serial_din, serial_dout, serial_dout_oe_n;
  logic store_status_out, store_status_oe_n;
  wire logic status_pin = store_status_oe_n ? 1'b1 : store_status_out;
  // no pull on the read-back line: a released line shows the inverse so a late enable shows
  wire logic dout_pin = serial_dout_oe_n ? !serial_dout : serial_dout;
  qdn_conv_type conv_out;
  int failures = 0;
  int n_checks = 0;
  logic [7:0] rd;
  always #2 core_clk = ~core_clk;
  qdn_core #(.STORE_CYCLES_P(STORE_P)) dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .serial_clk(serial_clk), .chip_select_n(chip_select_n), .serial_din(serial_din),
    .serial_dout(serial_dout), .serial_dout_oe_n(serial_dout_oe_n), .ext_mute(ext_mute),
    .store_status_in(status_pin), .store_status_out(store_status_out),
    .store_status_oe_n(store_status_oe_n), .conv_out(conv_out));
  qdn_host host (.core_clk(core_clk), .serial_clk(serial_clk),
    .chip_select_n(chip_select_n), .serial_din(serial_din), .serial_dout(dout_pin));
  // ====================
  // shared tasks
  task automatic check(input logic [41:0] seen, input logic [41:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish;
    if (failures == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc
  task automatic send(input qdn_cmd_type c, input logic [2:0] s, input logic [7:0] d);
    host.frame({1'b1, c, s, d}, 14, rd);
  endtask : send
  task automatic wait_ready;
    for (int i = 0; i < 100 && status_pin !== 1'b1; i++) cyc(1);
    if (status_pin !== 1'b1) begin
      failures++;
      tally_and_finish();
    end
  endtask : wait_ready
  // ====================
  // scenarios
  task automatic t_vol_write;
    for (int ch = 0; ch < 4; ch++) begin
      send(CMD_VOL_WR, 3'(ch), 8'hA0 + 8'(ch));
      check(42'(conv_out.code[ch]), 42'(8'hA0 + 8'(ch)));
    end
    check(42'(conv_out.code), 42'(32'hA3A2A1A0));
  endtask : t_vol_write
  task automatic t_nv_write;
    send(CMD_NV_WR, 3'h2, 8'h5A);
    cyc(4);
    check(42'(status_pin), 42'h0);
    check(42'(conv_out.code), 42'(32'hA3A2A1A0));
    wait_ready();
    send(CMD_NV_RD, 3'h2, 8'hFF);
    check(42'(rd), 42'h5A);
    check(42'(conv_out.code), 42'(32'hA3A2A1A0));
  endtask : t_nv_write
  task automatic t_mute;
    send(CMD_VOL_WR, SEL_MS, 8'h5A);
    check(42'({conv_out.mute, conv_out.hiz}), 42'h5A);
    ext_mute = 1'b1;
    cyc(6);
    check(42'(conv_out.mute), 42'hF);
    ext_mute = 1'b0;
    cyc(6);
    check(42'(conv_out.mute), 42'h5);
    send(CMD_VOL_WR, SEL_MS, 8'h00);
  endtask : t_mute
  task automatic t_refused;
    host.frame({1'b1, CMD_NONE, 3'h0, 8'h11}, 14, rd);
    check(42'(status_pin), 42'h1);
    host.frame({1'b1, CMD_VOL_WR, 3'h5, 8'h11}, 14, rd);
    host.frame({1'b0, CMD_VOL_WR, 3'h0, 8'h11}, 14, rd);
    host.frame({1'b1, CMD_VOL_WR, 3'h1, 8'h11}, 13, rd);
    check(42'(conv_out.code), 42'(32'hA3A2A1A0));
  endtask : t_refused
  task automatic t_power_cycle;
    send(CMD_NV_WR, SEL_MS, 8'h30);
    cyc(4);
    wait_ready();
    send(CMD_VOL_WR, SEL_MS, 8'h0F);
    check(42'(conv_out.code), 42'h0);
    check(42'(conv_out.hiz), 42'hF);
    sys_rst = 1'b1;
    cyc(4);
    check(42'(conv_out), 42'h0);
    sys_rst = 1'b0;
    cyc(20);
    check(42'(conv_out), 42'({32'h005A0000, 4'h3, 4'h0}));
    send(CMD_NV_RD, SEL_MS, 8'h00);
    check(42'(rd), 42'h30);
  endtask : t_power_cycle
  initial begin
    cyc(16);
    sys_rst = 1'b0;
    cyc(20);
    check(42'(conv_out), 42'h0);
    t_vol_write();
    t_nv_write();
    t_mute();
    t_refused();
    t_power_cycle();
    tally_and_finish();
  end
endmodule : tb
